// ---- hw/gis_pkg.sv ----
`default_nettype none
package gis_pkg;
	localparam int          GIS_ADDR_W        = 8;
	localparam int          GIS_DATA_W        = 8;
	localparam int          GIS_PINS          = 3;
	localparam int          GIS_SYM_W         = 10;
	localparam int          GIS_SYM_LOW_W     = 8;
	localparam int          GIS_SYM_HIGH_W    = GIS_SYM_W - GIS_SYM_LOW_W;
	// Register offsets
	localparam logic [7:0]  GIS_OFF_PIN2_CFG  = 8'h04;
	localparam logic [7:0]  GIS_OFF_IN_LEVELS = 8'h05;
	localparam logic [7:0]  GIS_OFF_OUT_VALS  = 8'h06;
	localparam logic [7:0]  GIS_OFF_IDLE_LOW  = 8'h0d;
	localparam logic [7:0]  GIS_OFF_IDLE_HIGH = 8'h0e;
	// Field positions
	localparam int          GIS_BIT_DRIVE_EN  = 0;
	localparam int          GIS_PIN_DRIVEN    = 2;
	// Reset values
	localparam logic        GIS_RST_DRIVE_EN  = 1'h1;
	localparam logic [7:0]  GIS_RST_IDLE_LOW  = 8'h83;
	localparam logic [1:0]  GIS_RST_IDLE_HIGH = 2'h2;
	localparam logic [2:0]  GIS_RST_OUT_VALS  = 3'h0;
	localparam logic [7:0]  GIS_ZERO_BYTE     = 8'h00;
endpackage
`default_nettype wire

// ---- hw/gis_pin_sync.sv ----
`default_nettype none
module gis_pin_sync
	import gis_pkg::*;
#(
	parameter int WIDTH = GIS_PINS
) (
	input  wire logic             clk,      // Register clock
	input  wire logic             rst_n,    // Synchronised reset
	input  wire logic             ce,       // Clock enable
	input  wire logic [WIDTH-1:0] pin_in,   // Raw pin levels
	output logic      [WIDTH-1:0] level_q   // Filtered levels
);
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_pin
			logic s1_q;
			logic s2_q;
			logic s3_q;
			// Level only moves once stages two and three agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1_q <= 1'b0;
					s2_q <= 1'b0;
					s3_q <= 1'b0;
					level_q[g] <= 1'b0;
				end else if (ce) begin
					s1_q <= pin_in[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						level_q[g] <= s3_q;
					end
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ---- hw/gis_regs.sv ----
// Contract
// RL1: Pin two floats at drive-enable 0, driven at 1; resets to 1.
// RL2: Input register returns levels of input pins, bit n for pin n.
// RL3: Output-configured pins are driven from matching output-register bit.
// RL4: In asynchronous mode, idle-character symbols are recognised as filler.
// RL5: Idle character defaults to K28.5 and is software redefinable.
// RL6: Low idle register holds bits 7..0 (83h); high holds 9..8 (2).
// RL7: Software disables driver for input use, input buffer for output use.
// RL8: Reserved bits and addresses read zero and ignore writes.
`default_nettype none
module gis_regs
	import gis_pkg::*;
(
	input  wire logic                  clk,           // 20 MHz register clock
	input  wire logic                  arst_n,        // Async reset, low
	input  wire logic                  ce,            // Clock enable
	input  wire logic [GIS_ADDR_W-1:0] reg_addr,      // Register address
	input  wire logic                  reg_wr,        // Write strobe
	input  wire logic [GIS_DATA_W-1:0] reg_wdata,     // Write data
	input  wire logic                  reg_rd,        // Read strobe
	output logic      [GIS_DATA_W-1:0] reg_rdata_q,   // Read data
	output logic                       reg_rvalid_q,  // Read data valid
	input  wire logic [GIS_PINS-1:0]   pin_in_mode,   // Pin used as input
	input  wire logic [GIS_PINS-1:0]   pin_out_mode,  // Pin used as output
	input  wire logic [GIS_PINS-1:0]   pin_i,         // Pin levels in
	output logic      [GIS_PINS-1:0]   pin_o_q,       // Pin levels out
	output logic      [GIS_PINS-1:0]   pin_oe_q,      // Pin drive enables
	input  wire logic                  asi_mode,      // Asynchronous mode
	input  wire logic [GIS_SYM_W-1:0]  sym_in,        // Decoded symbol
	input  wire logic                  sym_valid,     // Symbol strobe
	output logic                       idle_hit_q,    // Filler seen pulse
	output logic      [GIS_SYM_W-1:0]  payload_q,     // Payload symbol
	output logic                       payload_vld_q, // Payload pulse
	output logic      [GIS_SYM_W-1:0]  idle_sym_q     // Active idle char
);
	logic                      rst_a_q;
	logic                      rst_n;
	logic                      drive_en_q;
	logic [GIS_PINS-1:0]       out_vals_q;
	logic [GIS_SYM_LOW_W-1:0]  idle_low_q;
	logic [GIS_SYM_HIGH_W-1:0] idle_high_q;
	logic [GIS_PINS-1:0]       in_level;
	logic [GIS_DATA_W-1:0]     rdata_d;
	logic [GIS_SYM_W-1:0]      idle_char;
	logic [GIS_PINS-1:0]       oe_d;
	wire                       wr_cfg;
	wire                       wr_out;
	wire                       wr_low;
	wire                       wr_high;
	wire                       sym_is_idle;

	function automatic logic hit(input logic [GIS_ADDR_W-1:0] a,
		input logic [GIS_ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Two-stage reset release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_a_q <= 1'b0;
			rst_n   <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n   <= rst_a_q;
		end
	end

	gis_pin_sync #(
		.WIDTH(GIS_PINS)
	) u_sync (
		.clk    (clk),
		.rst_n  (rst_n),
		.ce     (ce),
		.pin_in (pin_i),
		.level_q(in_level)
	);

	// RL8 unmapped writes dropped
	assign wr_cfg  = reg_wr && hit(reg_addr, GIS_OFF_PIN2_CFG);
	assign wr_out  = reg_wr && hit(reg_addr, GIS_OFF_OUT_VALS);
	assign wr_low  = reg_wr && hit(reg_addr, GIS_OFF_IDLE_LOW);
	assign wr_high = reg_wr && hit(reg_addr, GIS_OFF_IDLE_HIGH);

	// RL6 idle character assembly
	assign idle_char = {idle_high_q, idle_low_q};

	// RL8 read mux, reserved as zero
	always_comb begin
		rdata_d = GIS_ZERO_BYTE;
		if (hit(reg_addr, GIS_OFF_PIN2_CFG)) begin
			rdata_d[GIS_BIT_DRIVE_EN] = drive_en_q;
		end else if (hit(reg_addr, GIS_OFF_IN_LEVELS)) begin
			// RL2 only input-mode pins
			rdata_d[GIS_PINS-1:0] = in_level & pin_in_mode;
		end else if (hit(reg_addr, GIS_OFF_OUT_VALS)) begin
			rdata_d[GIS_PINS-1:0] = out_vals_q;
		end else if (hit(reg_addr, GIS_OFF_IDLE_LOW)) begin
			rdata_d = idle_low_q;
		end else if (hit(reg_addr, GIS_OFF_IDLE_HIGH)) begin
			rdata_d[GIS_SYM_HIGH_W-1:0] = idle_high_q;
		end
	end

	// RL1 pin two follows drive-enable; others follow output mode
	always_comb begin
		oe_d = pin_out_mode;
		oe_d[GIS_PIN_DRIVEN] = drive_en_q;
	end

	// RL4 filler match only in asynchronous mode
	assign sym_is_idle = asi_mode && (sym_in == idle_char);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			// RL5 default idle is K28.5
			drive_en_q  <= GIS_RST_DRIVE_EN;
			out_vals_q  <= GIS_RST_OUT_VALS;
			idle_low_q  <= GIS_RST_IDLE_LOW;
			idle_high_q <= GIS_RST_IDLE_HIGH;
		end else if (ce) begin
			if (wr_cfg) begin
				drive_en_q <= reg_wdata[GIS_BIT_DRIVE_EN];
			end
			if (wr_out) begin
				out_vals_q <= reg_wdata[GIS_PINS-1:0];
			end
			// RL5 software redefinition
			if (wr_low) begin
				idle_low_q <= reg_wdata;
			end
			if (wr_high) begin
				idle_high_q <= reg_wdata[GIS_SYM_HIGH_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_q  <= GIS_ZERO_BYTE;
			reg_rvalid_q <= 1'b0;
		end else if (ce) begin
			reg_rvalid_q <= reg_rd;
			if (reg_rd) begin
				reg_rdata_q <= rdata_d;
			end
		end
	end

	// RL3 output buffers from register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_o_q  <= GIS_RST_OUT_VALS;
			pin_oe_q <= {GIS_PINS{1'b0}};
		end else if (ce) begin
			pin_o_q  <= out_vals_q & pin_out_mode;
			pin_oe_q <= oe_d;
		end
	end

	// RL4 split filler from payload
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_hit_q    <= 1'b0;
			payload_vld_q <= 1'b0;
			payload_q     <= {GIS_SYM_W{1'b0}};
			idle_sym_q    <= {GIS_SYM_W{1'b0}};
		end else if (ce) begin
			idle_hit_q    <= sym_valid && sym_is_idle;
			payload_vld_q <= sym_valid && !sym_is_idle;
			idle_sym_q    <= idle_char;
			if (sym_valid && !sym_is_idle) begin
				payload_q <= sym_in;
			end
		end
	end

	// Checks
	sequence s_rd_req;
		ce && reg_rd;
	endsequence

	sequence s_rd_answer;
		##1 reg_rvalid_q;
	endsequence

	a_read_valid: assert property (@(posedge clk) disable iff (!rst_n) // RL8
		s_rd_req |-> s_rd_answer)
		else $error("read strobe not answered");

	a_drive_follow: assert property (@(posedge clk) disable iff (!rst_n) // RL1
		ce |=> pin_oe_q[GIS_PIN_DRIVEN] == $past(drive_en_q))
		else $error("pin two enable mismatch");

	a_cfg_write: assert property (@(posedge clk) disable iff (!rst_n) // RL1
		(ce && wr_cfg) |=> drive_en_q == $past(reg_wdata[GIS_BIT_DRIVE_EN]))
		else $error("drive enable not written");

	a_out_value: assert property (@(posedge clk) disable iff (!rst_n) // RL3
		(ce && wr_out) ##1 ce |=> pin_o_q == ($past(reg_wdata[GIS_PINS-1:0], 2)
			& $past(pin_out_mode)))
		else $error("output value not driven");

	a_in_read: assert property (@(posedge clk) disable iff (!rst_n) // RL2
		(s_rd_req and hit(reg_addr, GIS_OFF_IN_LEVELS)) |=>
		reg_rdata_q == {5'h00, $past(in_level & pin_in_mode)})
		else $error("input levels misread");

	a_high_rsvd: assert property (@(posedge clk) disable iff (!rst_n) // RL8
		(s_rd_req and hit(reg_addr, GIS_OFF_IDLE_HIGH)) |=>
		reg_rdata_q[GIS_DATA_W-1:GIS_SYM_HIGH_W] == 6'h00)
		else $error("reserved idle bits nonzero");

	a_idle_match: assert property (@(posedge clk) disable iff (!rst_n) // RL4
		(ce && sym_valid && asi_mode && sym_in == idle_char) |=>
		idle_hit_q && !payload_vld_q)
		else $error("idle symbol not recognised");

	a_no_idle_std: assert property (@(posedge clk) disable iff (!rst_n) // RL4
		(ce && !asi_mode && sym_valid) |=> !idle_hit_q && payload_vld_q)
		else $error("filler flagged outside async mode");

	a_idle_sym: assert property (@(posedge clk) disable iff (!rst_n) // RL6
		ce |=> idle_sym_q == {$past(idle_high_q), $past(idle_low_q)})
		else $error("idle character output wrong");

	a_reset_vals: assert property (@(posedge clk) // RL5
		$rose(rst_n) |->
		idle_char == {GIS_RST_IDLE_HIGH, GIS_RST_IDLE_LOW} && drive_en_q)
		else $error("reset defaults wrong");
endmodule
`default_nettype wire

// ---- testbench/gis_host.sv ----
`default_nettype none
module gis_host
	import gis_pkg::*;
(
	input  wire logic                  clk,       // Register clock
	output logic      [GIS_ADDR_W-1:0] reg_addr,  // Address
	output logic                       reg_wr,    // Write strobe
	output logic      [GIS_DATA_W-1:0] reg_wdata, // Write data
	output logic                       reg_rd     // Read strobe
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_addr  = 8'h00;
		reg_wr    = 1'h0;
		reg_wdata = 8'h00;
		reg_rd    = 1'h0;
	end
	// Idle gap after each strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'h1;
		@(posedge clk);
		reg_wr    <= 1'h0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'h1;
		@(posedge clk);
		reg_rd   <= 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- testbench/gis_regs_tb_top.sv ----
`default_nettype none
module gis_regs_tb_top
	import gis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 1'h0, arst_n = 1'h0, ce = 1'h1;
	logic        asi_mode = 1'h0, sym_valid = 1'h0;
	logic [9:0]  sym_in = 10'h000, s, payload_q, idle_sym_q;
	logic [2:0]  in_m = 3'h0, out_m = 3'h0, ext = 3'h0;
	logic [2:0]  pin_o_q, pin_oe_q;
	logic [7:0]  addr, wdata, rdata;
	logic        wr, rd_s, rvld, hit, pvld;
	logic [15:0] n;
	logic [31:0] v;
	int          fails = 0, checks_done = 0;
	logic [15:0] q[$];
	logic [10:0] sq[$];
	logic [10:0] sn;
	wire  [2:0]  pin_i = (pin_oe_q & pin_o_q) | (~pin_oe_q & ext);
	gis_host host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
		.reg_wdata(wdata), .reg_rd(rd_s));
	gis_regs dut (.clk(clk), .arst_n(arst_n), .ce(ce), .reg_addr(addr),
		.reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd_s),
		.reg_rdata_q(rdata), .reg_rvalid_q(rvld), .pin_in_mode(in_m),
		.pin_out_mode(out_m), .pin_i(pin_i), .pin_o_q(pin_o_q),
		.pin_oe_q(pin_oe_q), .asi_mode(asi_mode), .sym_in(sym_in),
		.sym_valid(sym_valid), .idle_hit_q(hit), .payload_q(payload_q),
		.payload_vld_q(pvld), .idle_sym_q(idle_sym_q));
	initial begin
		forever #25 clk = ~clk;
	end
	task automatic cmp(input string nm, input logic [9:0] e,
		input logic [9:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic cmp_rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] g);
		cmp($sformatf("rdata_%h", a), 10'(e), 10'(g));
	endtask
	task automatic cmp_pin(input string nm, input logic [2:0] e,
		input logic [2:0] g);
		cmp(nm, 10'(e), 10'(g));
	endtask
	task automatic cmp_sym(input string nm, input logic [9:0] e,
		input logic [9:0] g);
		cmp(nm, e, g);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		q.push_back({a, e});
		host.rd(a);
	endtask
	task automatic sym(input logic m, input logic [9:0] x,
		input logic e);
		sq.push_back({e, x});
		@(posedge clk);
		asi_mode  <= m;
		sym_in    <= x;
		sym_valid <= 1'h1;
		@(posedge clk);
		sym_valid <= 1'h0;
		@(negedge clk);
	endtask
	task automatic test_done();
		if (fails == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		if (rvld === 1'h1 && q.size() > 0) begin
			n = q.pop_front();
			cmp_rd(n[15:8], n[7:0], rdata);
		end
	end
	always @(posedge clk) begin
		if ((hit === 1'h1 || pvld === 1'h1) && sq.size() > 0) begin
			sn = sq.pop_front();
			cmp_sym("sym_hit", 10'(sn[10]), 10'(hit));
			cmp_sym("sym_pvld", 10'(!sn[10]), 10'(pvld));
			if (!sn[10])
				cmp_sym("sym_payload", sn[9:0], payload_q);
		end
	end
	initial begin
		repeat (5000) @(posedge clk);
		fails++;
		test_done();
	end
	initial begin
		v = $urandom(85);
		v = $urandom;
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		repeat (3) @(posedge clk);
		rd(GIS_OFF_PIN2_CFG, 8'h01);
		rd(GIS_OFF_IDLE_LOW, 8'h83);
		rd(GIS_OFF_IDLE_HIGH, 8'h02);
		rd(GIS_OFF_OUT_VALS, 8'h00);
		cmp_sym("idle_sym", 10'h283, idle_sym_q);
		for (int i = 7; i < 16; i += 8) begin
			host.wr(8'(i), 8'hff);
			rd(8'(i), 8'h00);
		end
		out_m <= 3'h5;
		host.wr(GIS_OFF_OUT_VALS, v[7:0] | 8'hf8);
		host.wr(GIS_OFF_IN_LEVELS, 8'hff);
		rd(GIS_OFF_OUT_VALS, {5'h0, v[2:0]});
		rd(GIS_OFF_IN_LEVELS, 8'h00);
		cmp_pin("pin_o", v[2:0] & 3'h5, pin_o_q);
		cmp_pin("pin_oe", 3'h5, pin_oe_q);
		host.wr(GIS_OFF_PIN2_CFG, 8'hfe);
		out_m <= 3'h0;
		in_m  <= 3'h6;
		ext   <= v[5:3];
		repeat (8) @(posedge clk);
		cmp_pin("pin_oe", 3'h0, pin_oe_q);
		rd(GIS_OFF_IN_LEVELS, {5'h0, v[5:3] & 3'h6});
		rd(GIS_OFF_PIN2_CFG, 8'h00);
		host.wr(GIS_OFF_IDLE_LOW, v[15:8]);
		host.wr(GIS_OFF_IDLE_HIGH, v[23:16]);
		rd(GIS_OFF_IDLE_HIGH, {6'h0, v[17:16]});
		// Frozen clock enable must drop the write
		@(posedge clk);
		ce <= 1'h0;
		host.wr(GIS_OFF_IDLE_LOW, ~v[15:8]);
		ce <= 1'h1;
		rd(GIS_OFF_IDLE_LOW, v[15:8]);
		s = {v[17:16], v[15:8]};
		@(negedge clk);
		cmp_sym("idle_sym", s, idle_sym_q);
		sym(1'h1, s, 1'h1);
		cmp_sym("idle_hit", 10'h1, 10'(hit));
		sym(1'h1, ~s, 1'h0);
		cmp_sym("idle_hit", 10'h0, 10'(hit));
		cmp_sym("payload", ~s, payload_q);
		sym(1'h0, s, 1'h0);
		cmp_sym("pay_vld", 10'h1, 10'(pvld));
		for (int i = 0; i < 20 && q.size() + sq.size() > 0; i++)
			@(posedge clk);
		if (q.size() + sq.size() > 0)
			fails++;
		test_done();
	end
endmodule
`default_nettype wire
